// ===== test_wdt_ctrl.sv
// self-checking testbench for the watchdog control register block
`timescale 1ns/1ps
module test_wdt_ctrl;
  import wdt_pkg::*;

  // ****************************************
  // design hookup
  // ****************************************
  logic              clk_sys_i;       // 100 MHz
  logic              reset_n_i;       // synchronous, active low
  logic [ADDR_W-1:0] addr_i;          // bus address
  logic [DATA_W-1:0] wr_data_i;       // bus write data
  logic              wr_i;            // write strobe
  logic              rd_i;            // read strobe
  logic [DATA_W-1:0] rd_data_o;       // read data
  logic              ext_osc_i;       // fake external counting clock
  logic              cpu_reset_o;     // reset pulse
  logic              nmi_o;           // nmi pulse
  logic              irq_o;           // irq pulse
  logic [3:0]        irq_route_o;     // routing field
  logic [1:0]        osc_div;         // pin divider
  int                miscompares;     // mismatch count
  int                samples_checked; // comparison count

  wdt_ctrl wdt_ctrl_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .ext_osc_i(ext_osc_i), .cpu_reset_o(cpu_reset_o), .nmi_o(nmi_o), .irq_o(irq_o),
    .irq_route_o(irq_route_o));

  // free running clock
  always #5 clk_sys_i = ~clk_sys_i;

  // pin edge every 2 cycles, slow enough for the 3-flop sync
  always @(posedge clk_sys_i)
  begin
    osc_div   <= osc_div + 2'h1;
    ext_osc_i <= osc_div[1];
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] expd);
    samples_checked++;
    if (seen !== expd)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  // one-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_sys_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  function automatic logic [23:0] cw(input logic en, input logic [1:0] act,
                                     input logic [2:0] fl, input logic [3:0] rt,
                                     input logic [7:0] cnt);
    return {en, act, fl, 6'h00, rt, cnt};
  endfunction

  // counts cycles from a restart to the first pulse; pulses last one cycle
  task automatic wait_pulse(input int per, input logic [2:0] which);
    int n;
    logic [2:0] seen;
    n = 0;
    seen = 3'h0;
    while (seen === 3'h0 && n < per * 1026 + 20)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
      seen = {cpu_reset_o, nmi_o, irq_o};
    end
    chk(24'(seen), 24'(which));
    chk(24'(n >= per * 1023 && n <= per * 1025 + 8), 24'h1);
    @(posedge clk_sys_i);
    #1;
    chk(24'({cpu_reset_o, nmi_o, irq_o}), 24'h0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [23:0] d;
    bus_rd(CTRL_ADDR, d);
    chk(d, 24'h000002);
    @(posedge clk_sys_i);
    #1;
    chk(rd_data_o, 24'h0);
    bus_rd(AUX_ADDR, d);
    chk(d, 24'h0);
    chk(24'(irq_route_o), 24'h0);
  endtask

  // every route, every action code, reserved bits stay zero
  task automatic t_fields;
    logic [23:0] d;
    for (int i = 0; i < 16; i++)
    begin
      bus_wr(CTRL_ADDR, cw(1'b0, 2'(i), 3'h7, 4'(i), 8'h01 << i[2:0]) | 24'h03f000);
      bus_rd(CTRL_ADDR, d);
      chk(d, cw(1'b0, 2'(i), 3'h0, 4'(i), 8'h01 << i[2:0]));
      chk(24'(irq_route_o), 24'(i));
    end
    bus_wr(8'h50, 24'hffffff);
    bus_rd(CTRL_ADDR, d);
    chk(d, cw(1'b0, 2'h3, 3'h0, 4'hf, 8'h80));
    bus_rd(8'h50, d);
    chk(d, 24'h0);
  endtask

  // arm, wait for the action, stop, then read the sticky flags
  task automatic t_timeout(input logic src, input logic [1:0] act, input logic [7:0] cnt,
                           input logic [2:0] which, input logic [2:0] fl);
    logic [23:0] d;
    bus_wr(AUX_ADDR, 24'(src));
    bus_wr(CTRL_ADDR, cw(1'b1, act, 3'h0, 4'h3, cnt));
    wait_pulse(src ? 4 : 8, which);
    bus_wr(CTRL_ADDR, cw(1'b0, act, 3'h0, 4'h3, cnt));
    bus_rd(CTRL_ADDR, d);
    chk(d, cw(1'b0, act, fl, 4'h3, cnt));
  endtask

  // write ones to all flags
  task automatic t_clear;
    logic [23:0] d;
    bus_wr(CTRL_ADDR, cw(1'b0, ACT_RESET, 3'h7, 4'h0, 8'h01));
    bus_rd(CTRL_ADDR, d);
    chk(d, cw(1'b0, ACT_RESET, 3'h0, 4'h0, 8'h01));
  endtask

  // setups that must never fire within a full exponent-10 span
  task automatic t_quiet(input logic [23:0] w, input logic [23:0] aux_exp);
    logic [23:0] d;
    int hits;
    bus_wr(CTRL_ADDR, w);
    bus_rd(AUX_ADDR, d);
    chk(d, aux_exp);
    hits = 0;
    repeat (4 * 1024 + 200)
    begin
      @(posedge clk_sys_i);
      #1;
      if ({cpu_reset_o, nmi_o, irq_o} !== 3'h0)
        hits++;
    end
    chk(24'(hits), 24'h0);
    // no action taken, so no flag may have been raised either
    bus_rd(CTRL_ADDR, d);
    chk(d, w);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    clk_sys_i = 1'b0;
    reset_n_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 24'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ext_osc_i = 1'b0;
    osc_div = 2'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_fields();
    t_timeout(1'b1, ACT_RESET, 8'h81, 3'h4, 3'h4);
    t_clear();
    t_timeout(1'b1, ACT_NMI, 8'h03, 3'h2, 3'h2);
    t_timeout(1'b1, ACT_NMI, 8'h01, 3'h4, 3'h6);
    t_clear();
    t_timeout(1'b1, ACT_IRQ, 8'h01, 3'h1, 3'h1);
    t_timeout(1'b1, ACT_IRQ, 8'h01, 3'h4, 3'h5);
    t_clear();
    t_timeout(1'b0, ACT_RESET, 8'h01, 3'h4, 3'h4);
    t_clear();
    bus_wr(AUX_ADDR, 24'h1);
    t_quiet(cw(1'b1, ACT_RESET, 3'h0, 4'h0, 8'h00), 24'h1);
    t_quiet(cw(1'b0, ACT_RESET, 3'h0, 4'h0, 8'h01), 24'h1);
    t_quiet(cw(1'b1, 2'h3, 3'h0, 4'h0, 8'h01), 24'h3);
    end_sim();
  end

  // about twice the expected run, well inside the cycle budget
  initial
  begin
    #850000;
    miscompares++;
    end_sim();
  end
endmodule

// ===== wdt_ctrl.sv
// watchdog control register: flags, routing, count setting and timeout actions
`timescale 1ns/1ps
module wdt_ctrl
  import wdt_pkg::*;
(
  input  wire logic              clk_sys_i,     // system clock, 100 MHz
  input  wire logic              reset_n_i,     // synchronous reset, active low
  input  wire logic [ADDR_W-1:0] addr_i,        // register byte address
  input  wire logic [DATA_W-1:0] wr_data_i,     // write data
  input  wire logic              wr_i,          // write strobe
  input  wire logic              rd_i,          // read strobe
  output logic      [DATA_W-1:0] rd_data_o,     // read data, cycle after rd_i
  input  wire logic              ext_osc_i,     // external counting clock pin
  output logic                   cpu_reset_o,   // cpu reset pulse
  output logic                   nmi_o,         // nmi pulse
  output logic                   irq_o,         // watchdog irq pulse
  output logic      [3:0]        irq_route_o    // irq line the request goes to
);

  // ****************************************
  // register state
  // ****************************************
  logic       run_en_r;                          // watchdog_run_enable
  logic [1:0] action_r;                          // timeout_action_select
  logic       reset_flag_r;                      // watchdog_reset_flag
  logic       nmi_flag_r;                        // nmi_timeout_flag
  logic       irq_flag_r;                        // irq_timeout_flag
  logic [3:0] route_r;                           // irq_route_select
  logic [7:0] count_set_r;                       // timeout_count_setting
  logic       src_ext_r;                         // 1: external oscillator
  logic       ctrl_wr;                           // write hits control register
  logic       aux_wr;                            // write hits aux register
  logic       expired;                           // timeout pulse from counter
  logic       ev_reset;                          // timeout resolves to reset
  logic       ev_nmi;                            // timeout resolves to nmi
  logic       ev_irq;                            // timeout resolves to irq
  logic [EXP_W:0] exponent;                      // decoded count setting

  // address decoding
  always_comb
  begin
    ctrl_wr = 1'b0;
    aux_wr  = 1'b0;
    if (wr_i && addr_i == CTRL_ADDR)
    begin
      ctrl_wr = 1'b1;
    end
    else if (wr_i && addr_i == AUX_ADDR)
    begin
      aux_wr = 1'b1;
    end
  end

  // plain read/write fields; a control write also services the timer
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      run_en_r    <= CTRL_RESET[RUN_EN_BIT];
      action_r    <= CTRL_RESET[ACT_HI:ACT_LO];
      route_r     <= CTRL_RESET[ROUTE_HI:ROUTE_LO];
      count_set_r <= CTRL_RESET[COUNT_HI:COUNT_LO];
    end
    else if (ctrl_wr)
    begin
      run_en_r    <= wr_data_i[RUN_EN_BIT];
      action_r    <= wr_data_i[ACT_HI:ACT_LO];
      route_r     <= wr_data_i[ROUTE_HI:ROUTE_LO];
      count_set_r <= wr_data_i[COUNT_HI:COUNT_LO];
    end
  end

  assign irq_route_o = route_r;
  a_route_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ctrl_wr |=> irq_route_o == $past(wr_data_i[ROUTE_HI:ROUTE_LO]))
    else $error("routing field not taken from write");

  // ****************************************
  // counting clock sources
  // ****************************************
  logic [2:0]       osc_sync_r;                  // pin synchroniser, stage 0 first
  logic             osc_level_r;                 // pin level once late stages agree
  logic             osc_agree;                   // stages 1 and 2 hold one value
  logic [DIV_W-1:0] div_r;                       // internal clock divider
  logic             int_tick;                    // one internal clock period
  logic             ext_tick;                    // one external clock period
  logic             tick;                        // selected counting tick

  // external pin, three stages; a level counts once stages 1 and 2 agree
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      osc_sync_r  <= 3'h0;
      osc_level_r <= 1'b0;
    end
    else
    begin
      osc_sync_r  <= {osc_sync_r[1:0], ext_osc_i};
      // a short disagreement between the late stages is never counted
      osc_level_r <= osc_agree ? osc_sync_r[2] : osc_level_r;
    end
  end

  assign osc_agree = (osc_sync_r[1] == osc_sync_r[2]);
  assign ext_tick  = osc_agree & osc_sync_r[2] & ~osc_level_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i || div_r == DIV_LAST)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  assign int_tick = (div_r == DIV_LAST);
  a_int_tick_rate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    int_tick |=> (!int_tick)[*7] ##1 int_tick)
    else $error("internal counting clock not one in eight");

  // source select; aux write restarts so no stale count mixes sources
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      src_ext_r <= 1'b0;
    end
    else if (aux_wr)
    begin
      src_ext_r <= wr_data_i[SRC_BIT];
    end
  end

  assign tick = src_ext_r ? ext_tick : int_tick;

  // ****************************************
  // timeout counter
  // ****************************************
  // lowest set bit picks exponent
  assign exponent = exp_decode(count_set_r);
  a_exp_decode: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    count_set_r[0] |-> exponent == {1'b1, EXP_LOW})
    else $error("bit zero of count setting not exponent ten");

  wdt_tick_counter wdt_tick_counter_inst (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .run_i      (run_en_r),
    .restart_i  (ctrl_wr || aux_wr),
    .tick_i     (tick),
    .exponent_i (exponent),
    .expired_o  (expired)
  );
  a_timer_stopped: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!run_en_r)[*2] |-> !expired)
    else $error("timeout while watchdog disabled");

  // ****************************************
  // timeout action
  // ****************************************
  // resolve action from field and flag
  always_comb
  begin
    ev_reset = 1'b0;
    ev_nmi   = 1'b0;
    ev_irq   = 1'b0;
    case (action_r)
      ACT_RESET: ev_reset = expired;
      ACT_NMI:
      begin
        ev_nmi   = expired & ~nmi_flag_r;
        ev_reset = expired &  nmi_flag_r;
      end
      ACT_IRQ:
      begin
        ev_irq   = expired & ~irq_flag_r;
        ev_reset = expired &  irq_flag_r;
      end
      // reserved setting: timeout is ignored
      default: ev_reset = 1'b0;
    endcase
  end

  // pulses registered so the cpu sees clean one-cycle outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      cpu_reset_o <= 1'b0;
      nmi_o       <= 1'b0;
      irq_o       <= 1'b0;
    end
    else
    begin
      cpu_reset_o <= ev_reset;
      nmi_o       <= ev_nmi;
      irq_o       <= ev_irq;
    end
  end
  a_flagged_reset: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    expired && ((action_r == ACT_NMI && nmi_flag_r) || (action_r == ACT_IRQ && irq_flag_r))
    |=> cpu_reset_o && !nmi_o && !irq_o)
    else $error("second timeout did not reset");

  // ****************************************
  // sticky flags, set beats write-one clear
  // ****************************************
  // nmi flag set and clear
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      nmi_flag_r <= CTRL_RESET[NMI_FLAG_BIT];
    end
    else
    begin
      nmi_flag_r <= ev_nmi | (nmi_flag_r & ~(ctrl_wr & wr_data_i[NMI_FLAG_BIT]));
    end
  end
  a_nmi_flag_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    expired && action_r == ACT_NMI && !nmi_flag_r |=> nmi_flag_r && nmi_o && !cpu_reset_o)
    else $error("nmi timeout did not flag and raise nmi");
  a_nmi_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ctrl_wr && wr_data_i[NMI_FLAG_BIT] && !ev_nmi |=> !nmi_flag_r)
    else $error("write one did not clear nmi flag");

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      irq_flag_r <= CTRL_RESET[IRQ_FLAG_BIT];
    end
    else
    begin
      irq_flag_r <= ev_irq | (irq_flag_r & ~(ctrl_wr & wr_data_i[IRQ_FLAG_BIT]));
    end
  end
  a_irq_flag_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    expired && action_r == ACT_IRQ && !irq_flag_r |=> irq_flag_r && irq_o && !cpu_reset_o)
    else $error("irq timeout did not flag and raise irq");

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      reset_flag_r <= CTRL_RESET[RST_FLAG_BIT];
    end
    else
    begin
      reset_flag_r <= ev_reset | (reset_flag_r & ~(ctrl_wr & wr_data_i[RST_FLAG_BIT]));
    end
  end
  a_reset_flag: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    expired && action_r == ACT_RESET |=> cpu_reset_o && reset_flag_r)
    else $error("reset timeout did not pulse and flag");

  // ****************************************
  // read back
  // ****************************************
  // data stands one cycle only; unmapped and idle cycles read zero
  always_ff @(posedge clk_sys_i)
  begin
    rd_data_o <= RD_ZERO;
    if (reset_n_i && rd_i && addr_i == CTRL_ADDR)
    begin
      rd_data_o[RUN_EN_BIT]        <= run_en_r;
      rd_data_o[ACT_HI:ACT_LO]     <= action_r;
      rd_data_o[RST_FLAG_BIT]      <= reset_flag_r;
      rd_data_o[NMI_FLAG_BIT]      <= nmi_flag_r;
      rd_data_o[IRQ_FLAG_BIT]      <= irq_flag_r;
      rd_data_o[ROUTE_HI:ROUTE_LO] <= route_r;
      rd_data_o[COUNT_HI:COUNT_LO] <= count_set_r;
    end
    else if (reset_n_i && rd_i && addr_i == AUX_ADDR)
    begin
      rd_data_o[SRC_BIT]    <= src_ext_r;
      rd_data_o[ACTIVE_BIT] <= run_en_r & exponent[EXP_W];
    end
  end

endmodule

// ===== wdt_pkg.sv
// constants, field layout and exponent decoding for the watchdog control block
// Contract
// - timeout nmi sets nmi flag; one clears
// - timeout irq sets irq flag; one clears
// - four-bit read/write irq routing field
// - timeout equals two-power-exponent counting clock ticks
// - zero count field has no exponent
// - count external 14.318MHz or internal 12.5MHz
// - timer runs only while enable set
// - two-bit action field picks reset, nmi, irq
// - timeout reset sets reset flag; one clears
package wdt_pkg;

  // ****************************************
  // register bus
  // ****************************************
  localparam int unsigned ADDR_W = 8;                    // byte address width
  localparam int unsigned DATA_W = 24;                   // control register width
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h44;       // watchdog_timer_control
  localparam logic [ADDR_W-1:0] AUX_ADDR  = 8'h60;       // clock source and status
  localparam logic [DATA_W-1:0] CTRL_RESET = 24'h000002; // enable off, exponent 20
  localparam logic [DATA_W-1:0] RD_ZERO   = 24'h000000;  // unmapped read answer

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned RUN_EN_BIT   = 23;             // watchdog_run_enable
  localparam int unsigned ACT_HI       = 22;             // timeout_action_select
  localparam int unsigned ACT_LO       = 21;
  localparam int unsigned RST_FLAG_BIT = 20;             // watchdog_reset_flag
  localparam int unsigned NMI_FLAG_BIT = 19;             // nmi_timeout_flag
  localparam int unsigned IRQ_FLAG_BIT = 18;             // irq_timeout_flag
  localparam int unsigned ROUTE_HI     = 11;             // irq_route_select
  localparam int unsigned ROUTE_LO     = 8;
  localparam int unsigned COUNT_HI     = 7;              // timeout_count_setting
  localparam int unsigned COUNT_LO     = 0;
  localparam int unsigned SRC_BIT      = 0;              // aux: 1 selects external clock
  localparam int unsigned ACTIVE_BIT   = 1;              // aux: timer counting, read only

  // ****************************************
  // action codes
  // ****************************************
  localparam logic [1:0] ACT_RESET = 2'h0;               // reset the cpu
  localparam logic [1:0] ACT_NMI   = 2'h1;               // nmi, reset if already flagged
  localparam logic [1:0] ACT_IRQ   = 2'h2;               // irq, reset if already flagged

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned SYS_CLK_KHZ = 100000;          // system clock rate
  localparam int unsigned INT_OSC_KHZ = 12500;           // internal counting clock
  localparam int unsigned EXT_OSC_KHZ = 14318;           // external oscillator pin
  localparam int unsigned INT_DIV     = SYS_CLK_KHZ / INT_OSC_KHZ;
  localparam int unsigned DIV_W       = 3;               // holds INT_DIV - 1
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);
  localparam int unsigned TIMER_W     = 27;              // holds two to the 26
  localparam int unsigned EXP_W       = 5;
  localparam logic [EXP_W-1:0] EXP_LOW  = 5'h0a;         // exponent for bit 0
  localparam logic [EXP_W-1:0] EXP_BIT1 = 5'h14;         // exponent for bit 1

  // lowest set bit wins; zero field gives no exponent
  function automatic logic [EXP_W:0] exp_decode(input logic [7:0] cnt);
    logic [EXP_W:0] res;
    res = '0;
    for (int i = 7; i >= 1; i--)
    begin
      if (cnt[i])
      begin
        res = {1'b1, EXP_BIT1 + EXP_W'(i - 1)};
      end
    end
    if (cnt[0])
    begin
      res = {1'b1, EXP_LOW};
    end
    return res;
  endfunction

endpackage

// ===== wdt_tick_counter.sv
// timeout counter that fires after two to the exponent counting ticks
`timescale 1ns/1ps
module wdt_tick_counter
  import wdt_pkg::*;
(
  input  wire logic             clk_sys_i,    // system clock
  input  wire logic             reset_n_i,    // synchronous reset, active low
  input  wire logic             run_i,        // count only while high
  input  wire logic             restart_i,    // clear the count
  input  wire logic             tick_i,       // one counting clock period
  input  wire logic [EXP_W:0]   exponent_i,   // valid flag above exponent
  output logic                  expired_o     // one-cycle timeout pulse
);

  logic [TIMER_W-1:0] count_r;                // ticks seen so far
  logic [TIMER_W-1:0] terminal;               // ticks to timeout
  logic               exp_ok;                 // exponent is usable

  assign exp_ok   = exponent_i[EXP_W];
  assign terminal = TIMER_W'(1) << exponent_i[EXP_W-1:0];

  // ****************************************
  // count and fire
  // ****************************************
  // count to terminal
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i || restart_i)
    begin
      count_r   <= '0;
      expired_o <= 1'b0;
    end
    // stopped when disabled, stopped without exponent
    else if (run_i && exp_ok && tick_i)
    begin
      // wrap to zero so the timer keeps firing until serviced
      if (count_r == terminal - TIMER_W'(1))
      begin
        count_r   <= '0;
        expired_o <= 1'b1;
      end
      else
      begin
        count_r   <= count_r + TIMER_W'(1);
        expired_o <= 1'b0;
      end
    end
    else
    begin
      expired_o <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // fires only at terminal
  a_fire_wraps: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    expired_o |-> count_r == '0 && $past(count_r) == $past(terminal) - TIMER_W'(1))
    else $error("timeout fired away from terminal count");

  a_zero_count: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!exp_ok)[*2] |-> !expired_o)
    else $error("timeout fired with zero count setting");

endmodule
